// *** core/alss_params.svh ***
`ifndef ALSS_PARAMS_SVH
`define ALSS_PARAMS_SVH
// Register byte offsets
`define ALSS_OFF_CTRL      8'h00
`define ALSS_OFF_LINK      8'h04
`define ALSS_OFF_CAL       8'h08
`define ALSS_OFF_STATUS    8'h0C
// Control register fields
`define ALSS_CTRL_SOFT_RST 0
`define ALSS_CTRL_LINK_EN  1
`define ALSS_CTRL_CAL_EN   2
`define ALSS_CTRL_OVERRANGE_ENABLE_CTRL   3
`define ALSS_CTRL_TRIG     4
// Link register fields
`define ALSS_LINK_MODE_LSB 0
`define ALSS_LINK_KM1_LSB  8
`define ALSS_LINK_SYNC_SEL 16
// Calibration register fields
`define ALSS_CAL_BG        0
`define ALSS_CAL_OFS       1
`define ALSS_CAL_THR_LSB   8
// Reset values
`define ALSS_CTRL_RST      5'h06
`define ALSS_LINK_RST      17'h00000
`define ALSS_CAL_RST       16'h0000
// Timing
`define ALSS_SOFT_RST_NS   1000
`define ALSS_CLK_NS        40
`define ALSS_SOFT_RST_CYC  \
  ((`ALSS_SOFT_RST_NS + `ALSS_CLK_NS - 1) / `ALSS_CLK_NS)
`define ALSS_CAL_RUN_CYC   64
`endif

// *** core/alss_pkg.sv ***
package alss_pkg;
  // Link state machine states
  typedef enum logic [3:0] {
    LNK_STOP  = 4'h1,
    LNK_SYNC  = 4'h2,
    LNK_ILAS  = 4'h4,
    LNK_DATA  = 4'h8
  } alss_link_t;
  // Calibration state machine states
  typedef enum logic [2:0] {
    CAL_STOP  = 3'h1,
    CAL_IDLE  = 3'h2,
    CAL_RUN   = 3'h4
  } alss_cal_t;
endpackage

// *** core/alss_sync2.sv ***
module alss_sync2
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Asynchronous level in, synchronised level out
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  // Next values of the two stages
  always_comb
  begin
    meta_d = d_i;
    sync_d = meta_q;
  end

  // Two flip-flop synchroniser, resets to the idle high pin level
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign q_o = sync_q;
endmodule

// *** core/alss_top.sv ***
// Register access over Wishbone and the address map were left to the implementer.
`include "alss_params.svh"

module alss_top
  import alss_pkg::*;
#(
  parameter int ILAS_MF = 4
)
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Sync request pins, active low request
  input  wire logic        sync_se_n_i,
  input  wire logic        sync_ts_n_i,
  // Link and calibration outputs
  output logic [3:0]       link_state_o,
  output logic             link_data_o,
  output logic             cal_busy_o,
  output logic             overrange_enable_ctrl_o,
  output logic [7:0]       link_mode_o
);
  logic        sync_se_n;
  logic        sync_ts_n;
  logic        sync_req;
  logic [4:0]  ctrl_q, ctrl_d;
  logic [16:0] link_q, link_d;
  logic [15:0] cal_q, cal_d;
  logic        ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic [7:0]  srst_q, srst_d;
  logic        trig_q, trig_d;
  logic        cal_done_q, cal_done_d;
  alss_link_t  lnk_q, lnk_d;
  alss_cal_t   cst_q, cst_d;
  logic [7:0]  mf_q, mf_d;
  logic [7:0]  frm_q, frm_d;
  logic [7:0]  ccnt_q, ccnt_d;
  logic        wr;
  logic        rd;
  logic        srst_busy;

  // Write lanes merged into a register image
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction

  // Pin synchronisers
  alss_sync2 u_sync_se
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (sync_se_n_i),
    .q_o   (sync_se_n)
  );
  alss_sync2 u_sync_ts
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (sync_ts_n_i),
    .q_o   (sync_ts_n)
  );

  // Selected sync request source
  assign sync_req = link_q[`ALSS_LINK_SYNC_SEL] ? ~sync_ts_n
                                                : ~sync_se_n;

  // Bus strobes, one access per request
  assign wr = cyc_i & stb_i & we_i & ~ack_q;
  assign rd = cyc_i & stb_i & ~we_i & ~ack_q;
  assign srst_busy = (srst_q != 8'h00);

  // Register file and bus answer
  always_comb
  begin
    logic [31:0] m;
    m      = 32'h00000000;
    ctrl_d = ctrl_q;
    link_d = link_q;
    cal_d  = cal_q;
    srst_d = srst_busy ? srst_q - 8'h01 : 8'h00;
    ack_d  = cyc_i & stb_i & ~ack_q;
    rdat_d = 32'h00000000;
    if (wr)
    begin
      case (adr_i)
        `ALSS_OFF_CTRL:
        begin
          m      = merge({27'h0, ctrl_q}, dat_i, sel_i);
          ctrl_d = m[4:0];
          if (m[`ALSS_CTRL_SOFT_RST])
          begin
            ctrl_d = `ALSS_CTRL_RST;
            link_d = `ALSS_LINK_RST;
            cal_d  = `ALSS_CAL_RST;
            srst_d = 8'(`ALSS_SOFT_RST_CYC);
          end
        end
        `ALSS_OFF_LINK:
        begin
          m      = merge({15'h0, link_q}, dat_i, sel_i);
          link_d = m[16:0];
        end
        `ALSS_OFF_CAL:
        begin
          m     = merge({16'h0, cal_q}, dat_i, sel_i);
          cal_d = m[15:0];
        end
        default: m = 32'h00000000;
      endcase
      ctrl_d[`ALSS_CTRL_SOFT_RST] = 1'b0;
    end
    if (rd)
    begin
      case (adr_i)
        `ALSS_OFF_CTRL:   rdat_d = {27'h0, ctrl_q};
        `ALSS_OFF_LINK:   rdat_d = {15'h0, link_q};
        `ALSS_OFF_CAL:    rdat_d = {16'h0, cal_q};
        `ALSS_OFF_STATUS: rdat_d = {16'h0, 5'h0, cal_done_q, srst_busy,
                                    sync_req, 1'b0, cst_q, lnk_q};
        default:          rdat_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= `ALSS_CTRL_RST;
      link_q <= `ALSS_LINK_RST;
      cal_q  <= `ALSS_CAL_RST;
      srst_q <= 8'h00;
      ack_q  <= 1'b0;
      rdat_q <= 32'h00000000;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      link_q <= link_d;
      cal_q  <= cal_d;
      srst_q <= srst_d;
      ack_q  <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  // Link state machine
  always_comb
  begin
    lnk_d = lnk_q;
    mf_d  = mf_q;
    frm_d = frm_q;
    case (lnk_q)
      LNK_STOP:
      begin
        if (ctrl_q[`ALSS_CTRL_LINK_EN] && !srst_busy)
          lnk_d = LNK_SYNC;
      end
      LNK_SYNC:
      begin
        if (!sync_req)
        begin
          lnk_d = LNK_ILAS;
          mf_d  = 8'h00;
          frm_d = 8'h00;
        end
      end
      LNK_ILAS:
      begin
        if (sync_req)
          lnk_d = LNK_SYNC;
        else if (frm_q == link_q[`ALSS_LINK_KM1_LSB +: 8])
        begin
          frm_d = 8'h00;
          mf_d  = mf_q + 8'h01;
          if (mf_q == 8'(ILAS_MF - 1))
            lnk_d = LNK_DATA;
        end
        else
          frm_d = frm_q + 8'h01;
      end
      LNK_DATA:
      begin
        if (sync_req)
          lnk_d = LNK_SYNC;
      end
      default:
        lnk_d = LNK_STOP;
    endcase
    if (!ctrl_q[`ALSS_CTRL_LINK_EN])
      lnk_d = LNK_STOP;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lnk_q <= LNK_STOP;
      mf_q  <= 8'h00;
      frm_q <= 8'h00;
    end
    else
    begin
      lnk_q <= lnk_d;
      mf_q  <= mf_d;
      frm_q <= frm_d;
    end
  end

  // Calibration state machine
  always_comb
  begin
    cst_d      = cst_q;
    ccnt_d     = ccnt_q;
    cal_done_d = cal_done_q;
    trig_d     = ctrl_q[`ALSS_CTRL_TRIG];
    case (cst_q)
      CAL_STOP:
      begin
        if (ctrl_q[`ALSS_CTRL_CAL_EN] && !srst_busy)
          cst_d = CAL_IDLE;
      end
      CAL_IDLE:
      begin
        if (ctrl_q[`ALSS_CTRL_TRIG] && !trig_q)
        begin
          cst_d      = CAL_RUN;
          ccnt_d     = 8'h00;
          cal_done_d = 1'b0;
        end
      end
      CAL_RUN:
      begin
        ccnt_d = ccnt_q + 8'h01;
        if (ccnt_q == 8'(`ALSS_CAL_RUN_CYC - 1))
        begin
          cal_done_d = 1'b1;
          cst_d = cal_q[`ALSS_CAL_BG] ? CAL_RUN : CAL_IDLE;
          ccnt_d = 8'h00;
        end
      end
      default:
        cst_d = CAL_STOP;
    endcase
    if (!ctrl_q[`ALSS_CTRL_CAL_EN])
      cst_d = CAL_STOP;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cst_q      <= CAL_STOP;
      ccnt_q     <= 8'h00;
      cal_done_q <= 1'b0;
      trig_q     <= 1'b0;
    end
    else
    begin
      cst_q      <= cst_d;
      ccnt_q     <= ccnt_d;
      cal_done_q <= cal_done_d;
      trig_q     <= trig_d;
    end
  end

  // Registered outputs
  assign dat_o        = rdat_q;
  assign ack_o        = ack_q;
  assign link_state_o = lnk_q;
  assign link_data_o  = lnk_q[3]; // One-hot data state bit
  assign cal_busy_o   = cst_q[2]; // One-hot run state bit
  assign overrange_enable_ctrl_o     = ctrl_q[`ALSS_CTRL_OVERRANGE_ENABLE_CTRL];
  assign link_mode_o  = link_q[`ALSS_LINK_MODE_LSB +: 8];

  // Assertions
  link_halt_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctrl_q[`ALSS_CTRL_LINK_EN] |=> lnk_q == LNK_STOP)
    else $error("link not halted");
  cal_halt_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctrl_q[`ALSS_CTRL_CAL_EN] |=> cst_q == CAL_STOP)
    else $error("calibration not halted");
  cal_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cst_q == CAL_STOP && ctrl_q[`ALSS_CTRL_CAL_EN] && !srst_busy
    |=> cst_q == CAL_IDLE)
    else $error("calibration not restarted");
  link_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
    lnk_q == LNK_STOP && ctrl_q[`ALSS_CTRL_LINK_EN] && !srst_busy
    |=> lnk_q == LNK_SYNC)
    else $error("link not restarted");
  sync_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    lnk_q == LNK_DATA && sync_req && ctrl_q[`ALSS_CTRL_LINK_EN]
    |=> lnk_q == LNK_SYNC)
    else $error("link ignored sync request");
  trig_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cst_q == CAL_IDLE && $rose(ctrl_q[`ALSS_CTRL_TRIG])
    && ctrl_q[`ALSS_CTRL_CAL_EN] && $past(ctrl_q[`ALSS_CTRL_CAL_EN])
    |=> cst_q == CAL_RUN)
    else $error("trigger edge missed");
  cal_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(cst_q == CAL_RUN) |-> (cst_q == CAL_RUN)[*8])
    else $error("calibration run too short");
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_q |=> !ack_q)
    else $error("ack held two cycles");
  link_up_c: cover property (@(posedge clk_i) disable iff (rst_i)
    lnk_q == LNK_DATA);
  cal_done_c: cover property (@(posedge clk_i) disable iff (rst_i)
    $rose(cal_done_q));
  resync_c: cover property (@(posedge clk_i) disable iff (rst_i)
    lnk_q == LNK_DATA ##1 lnk_q == LNK_SYNC);
endmodule

// *** testbench/alss_rx_model.sv ***
module alss_rx_model
(
  // Bench commands
  input  wire logic req_i,
  input  wire logic pin_i,
  // Sync request pins, low asks for resync
  output logic      sync_se_n_o,
  output logic      sync_ts_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle high; low only on the chosen pin while resync is wanted
  assign sync_se_n_o = !(req_i && !pin_i);
  assign sync_ts_n_o = !(req_i && pin_i);
endmodule

// *** testbench/tb_alss_top.sv ***
`include "alss_params.svh"

module tb_alss_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TO = 400;
  // Clock, reset and bus
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i  = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic        ack_o;
  // Sync pins and observed outputs
  logic        sync_se_n_i;
  logic        sync_ts_n_i;
  logic        rx_req = 1'b0;
  logic        rx_pin = 1'b0;
  logic [3:0]  link_state_o;
  logic        link_data_o;
  logic        cal_busy_o;
  logic        overrange_enable_ctrl_o;
  logic [7:0]  link_mode_o;
  // Scoreboard
  int          failures = 0;
  int          samples_checked = 0;
  logic [31:0] rnd = 32'h0000B5DA;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  wire  [15:0] obs = {1'b0, link_mode_o, overrange_enable_ctrl_o, cal_busy_o,
                      link_data_o, link_state_o};

  always #20 clk_i = ~clk_i;

  alss_top #(.ILAS_MF(1)) i_alss_top (.clk_i, .rst_i, .cyc_i, .stb_i,
    .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .sync_se_n_i,
    .sync_ts_n_i, .link_state_o, .link_data_o, .cal_busy_o, .overrange_enable_ctrl_o,
    .link_mode_o);
  alss_rx_model i_alss_rx_model (.req_i(rx_req), .pin_i(rx_pin),
    .sync_se_n_o(sync_se_n_i), .sync_ts_n_o(sync_ts_n_i));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic complete_run;
    $display("checked %0d, wrong %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic guard(input int n);
    if (n >= TO)
    begin
      failures++;
      $display("wrong value at %0t: wait ran out", $time);
      complete_run;
    end
  endtask

  task automatic cmp(input logic [31:0] got, ex, m, input string what);
    samples_checked++;
    if ((got & m) !== (ex & m))
    begin
      failures++;
      $display("wrong value at %0t: %s got %h", $time, what, got);
    end
  endtask

  // One bus cycle; a read files its expectation
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [31:0] m = '1);
    int n;
    if (!w)
    begin
      exp_q.push_back(d);
      msk_q.push_back(m);
    end
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= 4'hF;
    dat_i <= w ? d : 32'h0;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < TO);
    guard(n);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Wait until masked outputs match, then compare
  task automatic see(input logic [15:0] m, v);
    int n;
    n = 0;
    while ((obs & m) !== v && n < TO)
    begin
      @(posedge clk_i);
      n++;
    end
    guard(n);
    cmp({16'h0, obs}, {16'h0, v}, {16'h0, m}, "pins");
  endtask

  // Read results against oldest note
  always @(posedge clk_i)
    if (ack_o === 1'b1 && we_i === 1'b0)
      cmp(dat_o, exp_q.pop_front(), msk_q.pop_front(), "read");

  initial
  begin
    int n;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(0, `ALSS_OFF_CTRL, {27'h0, `ALSS_CTRL_RST});
    wb(1, 8'h10, 32'hFFFFFFFF);
    wb(0, 8'h10, 32'h0);
    $display("reset and unmapped done");
    wb(1, `ALSS_OFF_CTRL, 32'h1);
    wb(0, `ALSS_OFF_STATUS, 32'h200, 32'h200);
    repeat (`ALSS_SOFT_RST_CYC) @(posedge clk_i);
    wb(0, `ALSS_OFF_CTRL, {27'h0, `ALSS_CTRL_RST});
    $display("soft reset done");
    wb(1, `ALSS_OFF_CTRL, 32'h0);
    see(16'h000F, 16'h0001);
    wb(0, `ALSS_OFF_STATUS, 32'h10, 32'h70);
    rnd = xs(rnd);
    wb(1, `ALSS_OFF_LINK, {24'h0, rnd[7:0]});
    wb(0, `ALSS_OFF_LINK, {24'h0, rnd[7:0]});
    see(16'h7F80, {1'b0, rnd[7:0], 7'h0});
    wb(1, `ALSS_OFF_CAL, 32'h0);
    wb(1, `ALSS_OFF_CTRL, 32'h4);
    wb(0, `ALSS_OFF_STATUS, 32'h21, 32'h7F);
    wb(1, `ALSS_OFF_CTRL, 32'hC);
    see(16'h0040, 16'h0040);
    wb(1, `ALSS_OFF_CTRL, 32'hE);
    $display("stop and settings done");
    for (int s = 0; s < 2; s++)
    begin
      wb(1, `ALSS_OFF_LINK, {15'h0, s[0], 8'h00, rnd[7:0]});
      see(16'h001F, 16'h0018);
      rx_pin <= !s[0];
      rx_req <= 1'b1;
      repeat (8) @(posedge clk_i);
      see(16'h0010, 16'h0010);
      rx_pin <= s[0];
      see(16'h000F, 16'h0002);
      rx_req <= 1'b0;
      see(16'h001F, 16'h0018);
    end
    $display("link restart done");
    wb(1, `ALSS_OFF_CTRL, 32'hE);
    wb(1, `ALSS_OFF_CTRL, 32'h1E);
    see(16'h0020, 16'h0020);
    n = 0;
    while (cal_busy_o === 1'b1 && n < TO)
    begin
      @(posedge clk_i);
      n++;
    end
    cmp(32'(n), `ALSS_CAL_RUN_CYC, '1, "run length");
    wb(0, `ALSS_OFF_STATUS, 32'h420, 32'h470);
    wb(1, `ALSS_OFF_CTRL, 32'h1E);
    repeat (8) @(posedge clk_i);
    see(16'h0020, 16'h0000);
    $display("calibration done");
    rnd = xs(rnd);
    wb(1, `ALSS_OFF_CAL, {16'h0, rnd[15:8], 8'h03});
    wb(0, `ALSS_OFF_CAL, {16'h0, rnd[15:8], 8'h03});
    wb(1, `ALSS_OFF_CTRL, 32'hE);
    wb(1, `ALSS_OFF_CTRL, 32'h1E);
    see(16'h0020, 16'h0020);
    repeat (`ALSS_CAL_RUN_CYC + 8) @(posedge clk_i);
    see(16'h0020, 16'h0020);
    wb(0, `ALSS_OFF_STATUS, 32'h440, 32'h470);
    wb(1, `ALSS_OFF_CTRL, 32'hA);
    see(16'h0020, 16'h0000);
    wb(0, `ALSS_OFF_STATUS, 32'h10, 32'h70);
    $display("background calibration done");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(0, `ALSS_OFF_CTRL, {27'h0, `ALSS_CTRL_RST});
    see(16'h7FFF, 16'h0018);
    $display("second reset done");
    complete_run;
  end
endmodule
